//--- logic/vim_arbiter.sv
`timescale 1ns/10ps
module vim_arbiter
	import vim_pkg::*;
#(
	parameter int N = NUM_PERIPH
) (
	input  wire logic [N-1:0]        req_in,
	input  wire logic [N*PRIO_W-1:0] prio_in,
	output vim_pick_type             pick_out
);
	import vim_pkg::*;
	// linear scan: lower line wins a tie because only strictly lower prio replaces
	always_comb begin
		pick_out = '0;
		for (int i = 0; i < N; i++) begin
			if (req_in[i] && (!pick_out.valid || prio_in[i*PRIO_W +: PRIO_W] < pick_out.prio)) begin
				pick_out.valid = 1'b1;
				pick_out.line  = LINE_W'(i);
				pick_out.prio  = prio_in[i*PRIO_W +: PRIO_W];
			end
		end
	end
endmodule : vim_arbiter

//--- logic/vim_ctrl.sv
`timescale 1ns/10ps
module vim_ctrl (
	input  wire logic                              core_clk_in,
	input  wire logic                              rst_in,
	input  wire logic [vim_pkg::NUM_PERIPH-1:0]    irq_src_in,
	input  wire logic [vim_pkg::NUM_PERIPH-1:0]    irq_enable_in,
	input  wire logic [vim_pkg::NUM_PERIPH-1:0]    sw_set_pend_in,
	input  wire logic [vim_pkg::NUM_PERIPH*vim_pkg::PRIO_W-1:0] prio_in,
	input  wire logic [vim_pkg::NUM_PERIPH-1:0]    group_member_in,
	input  wire logic [vim_pkg::PRIO_W-1:0]        group_prio_in,
	input  wire logic                              sw_reset_req_in,
	input  wire logic                              core_ack_in,
	input  wire logic                              core_return_in,
	output vim_pkg::vim_take_type                  take_out,
	output logic                                   sys_reset_req_out,
	output logic [vim_pkg::PRIO_W:0]               nest_depth_out
);
	import vim_pkg::*;

	typedef enum logic [1:0] {
		S_IDLE  = 2'b00,
		S_OFFER = 2'b01,
		S_RUN   = 2'b10
	} vim_state_type;

	function automatic logic [ADDR_W-1:0] vec_of(input logic [LINE_W-1:0] line);
		vec_of = VEC_BASE + {{(ADDR_W-LINE_W-2){1'b0}}, line, 2'b00};
	endfunction : vec_of

	vim_state_type               state_r;
	logic [NUM_PERIPH-1:0]       pend_r;
	logic [NUM_PERIPH-1:0]       pend_nxt;
	logic [NUM_PERIPH-1:0]       active_r;
	logic [NUM_PERIPH-1:0]       elig;
	logic [NUM_PERIPH*PRIO_W-1:0] eff_prio;
	logic [PRIO_W-1:0]           run_prio_r [0:NUM_LEVELS];
	logic [LINE_W-1:0]           run_line_r [0:NUM_LEVELS];
	logic [PRIO_W:0]             depth_r;
	logic [PRIO_W:0]             depth_eff;
	vim_pick_type                pick;
	vim_take_type                take_r;
	logic                        preempt;
	logic                        take_fire;
	logic                        ret_fire;

	// effective priority: group members share the group level
	genvar g;
	generate
		for (g = 0; g < NUM_PERIPH; g++) begin : g_prio
			assign eff_prio[g*PRIO_W +: PRIO_W] = group_member_in[g] ? group_prio_in
				: prio_in[g*PRIO_W +: PRIO_W];
		end
	endgenerate

	// unused and reserved lines never reach the arbiter, whatever is wired
	assign elig = pend_r & irq_enable_in & ~active_r & USED_MASK;

	vim_arbiter #(
		.N (NUM_PERIPH)
	) u_arb (
		.req_in   (elig),
		.prio_in  (eff_prio),
		.pick_out (pick)
	);

	// a request only preempts when strictly more urgent than the running one
	// a finishing handler no longer blocks: the next one chains straight on
	assign depth_eff = ret_fire ? depth_r - 1'b1 : depth_r;
	assign preempt   = pick.valid && (depth_eff == '0 || pick.prio < run_prio_r[depth_eff]);
	assign take_fire = take_r.valid && core_ack_in;
	assign ret_fire  = core_return_in && depth_r != '0;

	// peripheral side enable must also be high: irq_src_in is already gated there
	always_comb begin
		pend_nxt = pend_r | (irq_src_in & irq_enable_in) | sw_set_pend_in;
		if (take_fire) begin
			// set wins over the ack clear
			pend_nxt[take_r.line] = (irq_src_in[take_r.line] & irq_enable_in[take_r.line])
				| sw_set_pend_in[take_r.line];
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pend_r <= '0;
		end else begin
			pend_r <= pend_nxt;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			active_r <= '0;
			depth_r  <= '0;
			for (int k = 0; k <= NUM_LEVELS; k++) begin
				run_prio_r[k] <= PRIO_RESET;
				run_line_r[k] <= '0;
			end
		end else if (take_fire) begin
			active_r[take_r.line]       <= 1'b1;
			depth_r                     <= depth_r + 1'b1;
			run_prio_r[depth_r + 1'b1]  <= eff_prio[take_r.line*PRIO_W +: PRIO_W];
			run_line_r[depth_r + 1'b1]  <= take_r.line;
		end else if (ret_fire) begin
			// handlers finish in reverse order: the top of the stack leaves
			active_r[run_line_r[depth_r]] <= 1'b0;
			depth_r                       <= depth_r - 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r <= S_IDLE;
			take_r  <= '0;
		end else begin
			case (state_r)
				S_IDLE, S_RUN: begin
					if (preempt && depth_eff < NUM_LEVELS) begin
						state_r          <= S_OFFER;
						take_r.valid     <= 1'b1;
						take_r.line      <= pick.line;
						take_r.vec_addr  <= vec_of(pick.line);
						take_r.tail_chain <= core_return_in;
					end else begin
						take_r.valid <= 1'b0;
						if (depth_r == '0) begin
							state_r <= S_IDLE;
						end
					end
				end
				S_OFFER: begin
					// late arrival: a more urgent line replaces the offer before ack
					if (core_ack_in) begin
						state_r      <= S_RUN;
						take_r.valid <= 1'b0;
					end else if (pick.valid && pick.prio < eff_prio[take_r.line*PRIO_W +: PRIO_W]) begin
						take_r.line     <= pick.line;
						take_r.vec_addr <= vec_of(pick.line);
					end
				end
				default: begin
					state_r <= S_IDLE;
					take_r  <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sys_reset_req_out <= 1'b0;
		end else begin
			sys_reset_req_out <= sw_reset_req_in;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			nest_depth_out <= '0;
		end else begin
			nest_depth_out <= depth_r;
		end
	end

	assign take_out = take_r;

	property p_vec_range;
		@(posedge core_clk_in) disable iff (rst_in)
		take_r.valid |-> (take_r.vec_addr >= VEC_BASE && take_r.vec_addr <= VEC_LAST);
	endproperty
	a_vec_range: assert property (p_vec_range) else $error("vector out of table");

	property p_vec_calc;
		@(posedge core_clk_in) disable iff (rst_in)
		take_r.valid |-> take_r.vec_addr == VEC_BASE + 32'(take_r.line) * 4;
	endproperty
	a_vec_calc: assert property (p_vec_calc) else $error("vector address mismatch");

	property p_used_only;
		@(posedge core_clk_in) disable iff (rst_in)
		take_r.valid |-> USED_MASK[take_r.line];
	endproperty
	a_used_only: assert property (p_used_only) else $error("unused line offered");

	property p_enable_needed;
		@(posedge core_clk_in) disable iff (rst_in)
		$rose(take_r.valid) |-> (($past(irq_enable_in) >> take_r.line) & NUM_PERIPH'(1)) != '0;
	endproperty
	a_enable_needed: assert property (p_enable_needed) else $error("disabled line offered");

	property p_sw_pend;
		@(posedge core_clk_in) disable iff (rst_in)
		sw_set_pend_in[LINE_UART0] && !take_fire |=> pend_r[LINE_UART0];
	endproperty
	a_sw_pend: assert property (p_sw_pend) else $error("software pend lost");

	property p_reset_req;
		@(posedge core_clk_in) disable iff (rst_in)
		sw_reset_req_in |=> sys_reset_req_out;
	endproperty
	a_reset_req: assert property (p_reset_req) else $error("reset request not passed");

	property p_depth_up;
		@(posedge core_clk_in) disable iff (rst_in)
		take_fire |=> depth_r == $past(depth_r) + 1'b1 ##1 nest_depth_out == $past(depth_r);
	endproperty
	a_depth_up: assert property (p_depth_up) else $error("nesting not tracked");

	property p_depth_down;
		@(posedge core_clk_in) disable iff (rst_in)
		ret_fire && !take_fire |=> depth_r == $past(depth_r) - 1'b1;
	endproperty
	a_depth_down: assert property (p_depth_down) else $error("return not tracked");

	property p_active_clear;
		@(posedge core_clk_in) disable iff (rst_in)
		ret_fire && !take_fire |=> !active_r[$past(run_line_r[depth_r])];
	endproperty
	a_active_clear: assert property (p_active_clear) else $error("finished line still active");

	property p_best_prio;
		@(posedge core_clk_in) disable iff (rst_in)
		pick.valid |-> pick.prio <= eff_prio[LINE_TIMER_CH8_IRQ*PRIO_W +: PRIO_W] || !elig[LINE_TIMER_CH8_IRQ];
	endproperty
	a_best_prio: assert property (p_best_prio) else $error("priority order broken");

	property p_group;
		@(posedge core_clk_in) disable iff (rst_in)
		group_member_in[LINE_TIMER_CH8_IRQ] |-> eff_prio[LINE_TIMER_CH8_IRQ*PRIO_W +: PRIO_W] == group_prio_in;
	endproperty
	a_group: assert property (p_group) else $error("group priority ignored");
endmodule : vim_ctrl

//--- logic/vim_pkg.sv
package vim_pkg;
	localparam int NUM_PERIPH    = 64;
	localparam int NUM_SYS       = 16;
	localparam int NUM_UNUSED    = 25;
	localparam int PRIO_W        = 3;
	localparam int NUM_LEVELS    = 8;
	localparam int ADDR_W        = 32;
	localparam int LINE_W        = 6;
	localparam int SLOT_W        = 7;
	localparam logic [ADDR_W-1:0] VEC_BASE      = 32'h0000_0040;
	localparam logic [ADDR_W-1:0] VEC_LAST      = 32'h0000_013c;
	localparam logic [NUM_PERIPH-1:0] USED_MASK = 64'h0003_fbf3_3fff_61ef;
	localparam logic [PRIO_W-1:0] PRIO_RESET    = 3'h0;
	localparam logic [PRIO_W-1:0] GROUP_RESET   = 3'h0;
	localparam int LINE_TIMER_CH8_IRQ   = 13;
	localparam int LINE_TIMER9   = 14;
	localparam int LINE_PORT_A0  = 16;
	localparam int LINE_PWM0     = 24;
	localparam int LINE_PWM1     = 27;
	localparam int LINE_SPI0     = 32;
	localparam int LINE_I2C0     = 36;
	localparam int LINE_UART0    = 38;
	localparam int LINE_ADC0     = 43;
	localparam int LINE_CMP0     = 46;
	localparam int LINE_RSV0     = 50;

	typedef struct packed {
		logic              valid;
		logic [LINE_W-1:0] line;
		logic [PRIO_W-1:0] prio;
	} vim_pick_type;

	typedef struct packed {
		logic              valid;
		logic [LINE_W-1:0] line;
		logic [ADDR_W-1:0] vec_addr;
		logic              tail_chain;
	} vim_take_type;
endpackage : vim_pkg

//--- tb/testbench.sv
`timescale 1ns/10ps
module testbench;
	import vim_pkg::*;
	logic                         clk, rst = 1'b1, sw_rst, ack, ret, ack_en;
	logic [NUM_PERIPH-1:0]        src, en, pend, grp;
	logic [NUM_PERIPH*PRIO_W-1:0] prio;
	logic [PRIO_W-1:0]            gprio;
	vim_take_type                 take;
	logic                         sys_rst;
	logic [PRIO_W:0]              depth;
	int                           err_total, cmp_count;
	int                           lines[15] = '{13, 14, 16, 23, 24, 26, 27, 29, 32, 33, 36, 37, 41, 43, 49};
	vim_ctrl u_dut (.core_clk_in(clk), .rst_in(rst), .irq_src_in(src), .irq_enable_in(en),
		.sw_set_pend_in(pend), .prio_in(prio), .group_member_in(grp), .group_prio_in(gprio),
		.sw_reset_req_in(sw_rst), .core_ack_in(ack), .core_return_in(ret), .take_out(take),
		.sys_reset_req_out(sys_rst), .nest_depth_out(depth));
	vim_core_model u_core (.clk_in(clk), .rst_in(rst), .take_in(take), .ack_en_in(ack_en),
		.ack_out(ack), .return_out(ret));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	task automatic do_reset(input int n);
		@(posedge clk);
		rst <= 1'b1;
		{src, en, pend, grp, prio, gprio, sw_rst, ack_en} <= '0;
		repeat (n) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask : do_reset
	// bounded wait for an offer, then settle
	task automatic wait_offer(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
			if (take.valid === 1'b1) break;
		end
	endtask : wait_offer
	task automatic t_map();
		foreach (lines[i]) begin
			do_reset(2);
			src[lines[i]] <= 1'b1;
			en[lines[i]]  <= 1'b1;
			wait_offer(6);
			check(take.valid, 1);
			check(take.line, lines[i]);
			check(take.vec_addr, 32'h0000_0040 + 4 * lines[i]);
			check(take.tail_chain, 0);
		end
	endtask : t_map
	task automatic t_refuse();
		do_reset(2);
		src  <= 64'h0004_0040_0000_0010;
		en   <= ~64'h0000_0040_0000_0000;
		pend <= 64'h8000_0000_0000_0000;
		repeat (8) @(posedge clk);
		#1;
		check(take.valid, 0);
		@(posedge clk);
		en[38] <= 1'b1;
		wait_offer(6);
		check(take.valid, 1);
		check(take.line, 38);
		check(take.vec_addr, 32'h0000_00d8);
	endtask : t_refuse
	task automatic t_prio();
		logic [NUM_PERIPH*PRIO_W-1:0] p;
		p = '0;
		p[3*13 +: 3] = 3'h5;
		p[3*46 +: 3] = 3'h2;
		p[3*20 +: 3] = 3'h2;
		do_reset(2);
		en   <= '1;
		prio <= p;
		pend <= 64'h0000_4000_0010_2000;
		wait_offer(6);
		check(take.line, 20);
		check(take.vec_addr, 32'h0000_0090);
		// pend drops so line 13 is not pended again after its ack
		@(posedge clk);
		pend <= '0;
		grp  <= 64'h0000_0000_0000_2000;
		repeat (2) @(posedge clk);
		#1;
		check(take.line, 13);
		check(take.vec_addr, 32'h0000_0074);
		@(posedge clk);
		ack_en <= 1'b1;
		repeat (10) begin
			@(posedge clk);
			#1;
			if (ack === 1'b1) break;
		end
		repeat (2) @(posedge clk);
		#1;
		check(depth, 1);
		wait_offer(8);
		check(take.valid, 1);
		check(take.line, 20);
		check(take.tail_chain, 1);
	endtask : t_prio
	task automatic t_sw_reset();
		@(posedge clk);
		sw_rst <= 1'b1;
		@(posedge clk);
		sw_rst <= 1'b0;
		#1;
		check(sys_rst, 1);
		@(posedge clk);
		#1;
		check(sys_rst, 0);
	endtask : t_sw_reset
	initial begin
		err_total = 0;
		cmp_count = 0;
		do_reset(16);
		t_map();
		t_refuse();
		t_prio();
		t_sw_reset();
		report_and_stop();
	end
	// whole run is well under 1000 cycles
	initial begin
		#(50 * 5000);
		err_total++;
		report_and_stop();
	end
endmodule : testbench

//--- tb/vim_core_model.sv
`timescale 1ns/10ps
module vim_core_model (
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	input  wire vim_pkg::vim_take_type take_in,
	input  wire logic                  ack_en_in,
	output logic                       ack_out,
	output logic                       return_out
);
	import vim_pkg::*;
	logic [2:0] wait_r;
	logic [3:0] ret_r;
	// slow core: takes an offer only after it stood for 4 cycles
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wait_r <= 3'h0;
			ack_out <= 1'b0;
		end else begin
			ack_out <= ack_en_in && take_in.valid && !ack_out && wait_r == 3'h3;
			wait_r <= (ack_en_in && take_in.valid && !ack_out) ? wait_r + 3'h1 : 3'h0;
		end
	end
	// one return per take, five cycles later, so nesting stays paired
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ret_r <= 4'h0;
			return_out <= 1'b0;
		end else begin
			ret_r <= {ret_r[2:0], ack_out};
			return_out <= ret_r[3];
		end
	end
endmodule : vim_core_model
